// ==== inc/asp_map.svh ====
// Purpose: Offsets, field positions, reset values and widths of the sequencer status bank.
// Assumes: Wishbone byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ASP_OFS_UFLOW    8'h18
`define ASP_OFS_PRIO     8'h20
`define ASP_OFS_IRQ_EN   8'h24
`define ASP_OFS_IRQ_CLR  8'h2c
`define ASP_OFS_ADR_W    8

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ASP_NSEQ         4
`define ASP_PRIO_STRIDE  4
`define ASP_PRIO_W       2
`define ASP_PRIO_RST     32'h0000_3210
`define ASP_PRIO_MASK    32'h0000_3333
`define ASP_FLAG_MASK    32'h0000_000f

`endif

// ==== inc/asp_pkg.sv ====
// Purpose: Types shared by the sequencer status bank.
// Assumes: The constants header is included alongside.
// Notes: Carries the Wishbone request as one struct.
package asp_pkg;

    // ----------------------------------------------------------------
    // Bus request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } asp_wb_req_t;

    // ----------------------------------------------------------------
    // Slave answer state
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        ASP_IDLE = 1'b0,
        ASP_ACK  = 1'b1
    } asp_bus_st_t;

endpackage

// ==== hdl/asp_seq_status.sv ====
// Purpose: Underflow flags and priority arbitration for four sequencer result FIFOs.
// Assumes: One clock mclk; FIFO status and triggers are synchronous to it.
// Notes: Classic Wishbone slave, one wait state, interrupt on enabled underflow.
`timescale 1ns/1ps
`include "asp_map.svh"

module asp_seq_status
    import asp_pkg::*;
#(
    parameter int NSEQ = `ASP_NSEQ,
    parameter int DW   = 16
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    // Wishbone slave
    input  wire asp_wb_req_t           wbReq,
    output logic [31:0]                wbDatO,
    output logic                       wbAck,
    // FIFO read side
    input  wire logic [NSEQ-1:0]       fifoRdReq,
    input  wire logic [NSEQ-1:0]       fifoEmpty,
    input  wire logic [NSEQ*DW-1:0]    fifoRdData,
    output logic [NSEQ-1:0]            fifoRdPop,
    output logic [NSEQ*DW-1:0]         rdData,
    // Trigger arbitration
    input  wire logic [NSEQ-1:0]       seqEnable,
    input  wire logic [NSEQ-1:0]       seqTrigger,
    output logic [NSEQ-1:0]            seqGrant,
    // Interrupt
    output logic                       irq
);

    // ----------------------------------------------------------------
    // Reset synchroniser
    // ----------------------------------------------------------------
    logic rstMeta_r;
    logic rstSync_r;
    logic rstn;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end
    assign rstn = rstSync_r;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    function automatic logic hitWr(input asp_wb_req_t r, input logic [7:0] ofs);
        hitWr = r.cyc && r.stb && r.we && (r.adr == ofs) && r.sel[0];
    endfunction

    function automatic logic laneWr(input asp_wb_req_t r, input logic [7:0] ofs, input int lane);
        laneWr = r.cyc && r.stb && r.we && (r.adr == ofs) && r.sel[lane];
    endfunction

    asp_bus_st_t busSt_r;
    logic        reqOn;
    logic        rdTake;
    logic        wrTake;
    logic        wrFlags;
    logic        wrEn;
    logic        wrClr;

    assign reqOn   = wbReq.cyc && wbReq.stb;

    // Reads are taken while idle, so the data stands together with the acknowledge.
    assign rdTake  = reqOn && !wbReq.we && (busSt_r == ASP_IDLE);

    // Writes land at the edge at which the master samples the acknowledge.
    assign wrTake  = reqOn && wbReq.we && (busSt_r == ASP_ACK);

    assign wrFlags = wrTake && hitWr(wbReq, `ASP_OFS_UFLOW);
    assign wrEn    = wrTake && hitWr(wbReq, `ASP_OFS_IRQ_EN);
    assign wrClr   = wrTake && hitWr(wbReq, `ASP_OFS_IRQ_CLR);

    // ----------------------------------------------------------------
    // Bus answer state
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busSt_r <= ASP_IDLE;
        end else begin
            unique case (busSt_r)
                ASP_IDLE: begin
                    if (reqOn) begin
                        busSt_r <= ASP_ACK;
                    end
                end
                ASP_ACK: begin
                    busSt_r <= ASP_IDLE;
                end
            endcase
        end
    end

    assign wbAck = (busSt_r == ASP_ACK);

    // ----------------------------------------------------------------
    // Underflow flags
    // ----------------------------------------------------------------
    logic [NSEQ-1:0] uflow;
    logic [NSEQ-1:0] uflowSet;
    logic [NSEQ-1:0] clrMask;
    logic            uflowBit_r [NSEQ];

    assign uflowSet = fifoRdReq & fifoEmpty;

    assign clrMask  = (wrFlags || wrClr) ? wbReq.dat[NSEQ-1:0] : '0;

    genvar f;
    generate
        for (f = 0; f < NSEQ; f++) begin : gFlag
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    uflowBit_r[f] <= 1'b0;
                end else if (uflowSet[f]) begin
                    uflowBit_r[f] <= 1'b1;
                end else if (clrMask[f]) begin
                    uflowBit_r[f] <= 1'b0;
                end
            end

            assign uflow[f] = uflowBit_r[f];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Interrupt enable and output
    // ----------------------------------------------------------------
    logic [NSEQ-1:0] irqEn_r;
    logic [NSEQ-1:0] irqPend;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irqEn_r <= '0;
        end else if (wrEn) begin
            irqEn_r <= wbReq.dat[NSEQ-1:0];
        end
    end

    assign irqPend = uflow & irqEn_r;

    assign irq     = |irqPend;

    // ----------------------------------------------------------------
    // Priority fields
    // ----------------------------------------------------------------
    localparam logic [31:0] PRIO_RST  = `ASP_PRIO_RST;
    localparam logic [31:0] PRIO_MASK = `ASP_PRIO_MASK;

    logic [`ASP_PRIO_W-1:0] prioFld_r [NSEQ];
    logic [31:0]            prio;

    genvar p;
    generate
        for (p = 0; p < NSEQ; p++) begin : gPrio
            localparam int LSB  = p * `ASP_PRIO_STRIDE;
            localparam int LANE = LSB / 8;

            logic fieldWr;

            assign fieldWr = wrTake && laneWr(wbReq, `ASP_OFS_PRIO, LANE);

            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    prioFld_r[p] <= PRIO_RST[LSB +: `ASP_PRIO_W];
                end else if (fieldWr) begin
                    prioFld_r[p] <= wbReq.dat[LSB +: `ASP_PRIO_W];
                end
            end
        end
    endgenerate

    always_comb begin
        prio = '0;
        for (int k = 0; k < NSEQ; k++) begin
            prio[k*`ASP_PRIO_STRIDE +: `ASP_PRIO_W] = prioFld_r[k];
        end
        prio = prio & PRIO_MASK;
    end

    // ----------------------------------------------------------------
    // Trigger arbitration
    // ----------------------------------------------------------------
    logic [NSEQ-1:0] req;
    logic [NSEQ-1:0] beaten;
    logic [NSEQ-1:0] grantNxt;
    logic [NSEQ-1:0] grant_r;

    function automatic logic outranks(input logic [1:0] pj,
                                      input logic [1:0] pi,
                                      input int         j,
                                      input int         i);
        outranks = (pj < pi) || ((pj == pi) && (j < i));
    endfunction

    assign req = seqTrigger & seqEnable;

    always_comb begin
        beaten = '0;
        for (int i = 0; i < NSEQ; i++) begin
            for (int j = 0; j < NSEQ; j++) begin
                if (j != i && req[j] && outranks(prioFld_r[j], prioFld_r[i], j, i)) begin
                    beaten[i] = 1'b1;
                end
            end
        end
    end

    assign grantNxt = req & ~beaten;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            grant_r <= '0;
        end else begin
            grant_r <= grantNxt;
        end
    end

    assign seqGrant = grant_r;

    // ----------------------------------------------------------------
    // FIFO read gating
    // ----------------------------------------------------------------
    logic [DW-1:0] rdHold_r [NSEQ];

    genvar g;
    generate
        for (g = 0; g < NSEQ; g++) begin : gRd
            assign fifoRdPop[g] = fifoRdReq[g] && !fifoEmpty[g];

            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    rdHold_r[g] <= '0;
                end else if (fifoRdReq[g]) begin
                    rdHold_r[g] <= fifoEmpty[g] ? '0 : fifoRdData[g*DW +: DW];
                end
            end

            assign rdData[g*DW +: DW] = rdHold_r[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    function automatic logic [31:0] rdMux(input logic [7:0]      adr,
                                          input logic [NSEQ-1:0] fl,
                                          input logic [31:0]     pr,
                                          input logic [NSEQ-1:0] en);
        unique case (adr)
            `ASP_OFS_UFLOW: begin
                rdMux = {{(32-NSEQ){1'b0}}, fl};
            end
            `ASP_OFS_PRIO: begin
                rdMux = pr;
            end
            `ASP_OFS_IRQ_EN: begin
                rdMux = {{(32-NSEQ){1'b0}}, en};
            end
            default: begin
                rdMux = '0;
            end
        endcase
    endfunction

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wbDatO <= '0;
        end else if (rdTake) begin
            wbDatO <= rdMux(wbReq.adr, uflow, prio, irqEn_r);
        end
    end

endmodule

// ==== tb/asp_seq_status_props.sv ====
// Purpose: Bus, FIFO and arbiter checks.
// Assumes: Ports of asp_seq_status.
// Notes: Bound after the module.
`timescale 1ns/1ps
module asp_seq_status_props
    import asp_pkg::*;
#(
    parameter int NSEQ = 4,
    parameter int DW   = 16
) (
    // Clock, reset and bus
    input wire logic               mclk,
    input wire logic               resetn,
    input wire asp_wb_req_t        wbReq,
    input wire logic [31:0]        wbDatO,
    input wire logic               wbAck,
    // FIFO side
    input wire logic [NSEQ-1:0]    fifoRdReq,
    input wire logic [NSEQ-1:0]    fifoEmpty,
    input wire logic [NSEQ*DW-1:0] fifoRdData,
    input wire logic [NSEQ-1:0]    fifoRdPop,
    input wire logic [NSEQ*DW-1:0] rdData,
    // Arbiter and interrupt
    input wire logic [NSEQ-1:0]    seqEnable,
    input wire logic [NSEQ-1:0]    seqTrigger,
    input wire logic [NSEQ-1:0]    seqGrant,
    input wire logic               irq
);
    logic [NSEQ-1:0] reqQ_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) reqQ_r <= '0;
        else reqQ_r <= seqTrigger & seqEnable;
    end
    ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack too long");
    ack_answer_a: assert property ($rose(wbReq.cyc & wbReq.stb) |=> wbAck) else $error("no ack");
    pop_nonempty_a: assert property (fifoRdPop == (fifoRdReq & ~fifoEmpty)) else $error("bad pop");
    empty_zero_a: assert property (fifoRdReq[0] && fifoEmpty[0] |=> rdData[DW-1:0] == '0)
        else $error("empty read not zero");
    head_data_a: assert property (fifoRdReq[0] && !fifoEmpty[0] |=> rdData[DW-1:0] == $past(fifoRdData[DW-1:0]))
        else $error("bad head data");
    grant_onehot_a: assert property ($onehot0(seqGrant)) else $error("grant not one-hot");
    grant_cause_a: assert property ((seqGrant & ~reqQ_r) == '0) else $error("grant without request");
    grant_given_a: assert property (|reqQ_r |-> |seqGrant) else $error("request not granted");
endmodule
bind asp_seq_status asp_seq_status_props #(.NSEQ(NSEQ), .DW(DW)) u_props (
    .mclk(mclk), .resetn(resetn), .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck),
    .fifoRdReq(fifoRdReq), .fifoEmpty(fifoEmpty), .fifoRdData(fifoRdData), .fifoRdPop(fifoRdPop),
    .rdData(rdData), .seqEnable(seqEnable), .seqTrigger(seqTrigger), .seqGrant(seqGrant), .irq(irq));

// ==== tb/testbench.sv ====
// Purpose: Register, FIFO and arbiter tests.
// Assumes: One-wait-state Wishbone slave.
// Notes: Stops at the first timeout.
`timescale 1ns/1ps
module testbench;
    import asp_pkg::*;
    logic mclk, resetn, wbAck, irq;
    asp_wb_req_t wbReq;
    logic [31:0] wbDatO, rd;
    logic [3:0] fifoRdReq, fifoEmpty, fifoRdPop, seqEnable, seqTrigger, seqGrant;
    logic [63:0] fifoRdData, rdData;
    int mismatches, cmp_count;
    asp_seq_status u_dut (
        .mclk(mclk), .resetn(resetn), .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck),
        .fifoRdReq(fifoRdReq), .fifoEmpty(fifoEmpty), .fifoRdData(fifoRdData), .fifoRdPop(fifoRdPop),
        .rdData(rdData), .seqEnable(seqEnable), .seqTrigger(seqTrigger), .seqGrant(seqGrant), .irq(irq));
    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n = 0;
        @(posedge mclk);
        wbReq <= '{1'b1, 1'b1, we, 4'hf, adr, dat};
        do begin
            @(posedge mclk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatO;
        wbReq <= '0;
        if (n >= 20) begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic fr(input int i, input logic emp, input logic [15:0] exp);
        @(posedge mclk);
        fifoRdReq <= 4'h1 << i;
        fifoEmpty <= {4{emp}};
        #1 chk(fifoRdPop, emp ? 4'h0 : 4'h1 << i);
        @(posedge mclk);
        fifoRdReq <= '0;
        #1 chk(rdData[i*16+:16], exp);
    endtask
    task automatic arb(input logic [3:0] en, input logic [3:0] expg);
        @(posedge mclk);
        seqEnable <= en;
        seqTrigger <= 4'hf;
        @(posedge mclk);
        seqTrigger <= '0;
        #1 chk(seqGrant, expg);
    endtask
    initial begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        resetn = 0;
        wbReq = '0;
        fifoRdReq = 0;
        fifoEmpty = 0;
        seqEnable = 0;
        seqTrigger = 0;
        fifoRdData = 64'h4444_3333_2222_1111;
        mismatches = 0;
        cmp_count = 0;
        repeat (16) @(posedge mclk);
        resetn <= 1;
        repeat (3) @(posedge mclk);
        wb(0, 8'h18, 0);
        chk(rd, 0);
        wb(0, 8'h20, 0);
        chk(rd, 32'h3210);
        wb(0, 8'h30, 0);
        chk(rd, 0);
        arb(4'hf, 4'h1);
        fr(0, 0, 16'h1111);
        for (int i = 0; i < 4; i++) fr(i, 1, 16'h0);
        wb(0, 8'h18, 0);
        chk(rd, 32'hf);
        wb(1, 8'h24, 32'h4);
        #1 chk(irq, 1);
        wb(1, 8'h18, 32'h4);
        #1 chk(irq, 0);
        wb(1, 8'h18, 0);
        wb(0, 8'h18, 0);
        chk(rd, 32'hb);
        wb(1, 8'h2c, 32'h1);
        wb(0, 8'h18, 0);
        chk(rd, 32'ha);
        fifoEmpty <= 4'hf;
        fifoRdReq <= 4'h4;
        wb(1, 8'h18, 32'hf);
        fifoRdReq <= 0;
        #1 chk(irq, 1);
        wb(0, 8'h18, 0);
        chk(rd, 32'h4);
        wb(1, 8'h20, 32'h0123);
        wb(0, 8'h20, 0);
        chk(rd, 32'h0123);
        arb(4'hf, 4'h8);
        arb(4'h3, 4'h2);
        wrap_up();
    end
endmodule
